// >>> verilog/acas_unit.sv
// atomic compare-and-swap execution unit with wishbone registers
//
// The register offsets and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`include "acas_params.svh"

module acas_unit
    import acas_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // pipeline request
    input  wire logic        req_valid_i,
    output logic             req_ready_o,
    input  wire acas_req_t   req_i,
    // pipeline answer
    output logic             resp_valid_o,
    output logic             rd_we_o,
    output logic [63:0]      rd_data_o,
    output acas_fault_t      fault_o,
    output logic             ccr_we_o,
    output logic             intr_hold_o,
    // memory system
    output logic             mem_req_o,
    output acas_mem_t        mem_o,
    input  wire logic        mem_ack_i,
    input  wire logic        mem_err_i,
    input  wire logic [63:0] mem_rdata_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // interrupt
    output logic             irq_o
);

    // space table: the sixteen spaces accepted
    function automatic logic spc_ok(input logic [7:0] s);
        unique case (s)
            `ACAS_SPC_NUC, `ACAS_SPC_NUC_L,
            `ACAS_SPC_USR_P, `ACAS_SPC_USR_S,
            `ACAS_SPC_USR_P_L, `ACAS_SPC_USR_S_L,
            `ACAS_SPC_REAL, `ACAS_SPC_REAL_L,
            `ACAS_SPC_PRV_P, `ACAS_SPC_PRV_S,
            `ACAS_SPC_PRV_P_L, `ACAS_SPC_PRV_S_L,
            `ACAS_SPC_PRI, `ACAS_SPC_SEC,
            `ACAS_SPC_PRI_L, `ACAS_SPC_SEC_L: spc_ok = 1'b1;
            default: spc_ok = 1'b0;
        endcase
    endfunction

    // privilege check on the selected space
    function automatic logic spc_priv_bad(input logic [7:0] s,
                                          input logic       pv,
                                          input logic       hp);
        logic user;
        logic rsv;
        user = !pv && !hp;
        rsv  = (s >= `ACAS_SPC_RSV_LO) && (s <= `ACAS_SPC_RSV_HI);
        spc_priv_bad = (user && !s[`ACAS_SPC_PRIV_BIT])
                     || (pv && !hp && rsv);
    endfunction

    acas_state_t q;               // registered state
    acas_state_t d;               // next state

    // request decode
    logic [5:0]  opf;             // operation_field
    logic        is_word;         // word variant
    logic        is_dbl;          // doubleword variant
    logic        isel;            // immediate select bit
    logic [7:0]  imm_spc;         // immediate space field
    logic [7:0]  sel_spc;         // space actually used
    logic        accept;          // request taken this edge
    logic        mem_hit;         // comparison outcome
    logic        wb_req;          // new wishbone access
    logic [7:0]  wb_off;          // register offset

    always_comb
    begin
        opf     = req_i.instr[`ACAS_OPF_HI:`ACAS_OPF_LO];
        isel    = req_i.instr[`ACAS_ISEL_BIT];
        imm_spc = req_i.instr[`ACAS_IMM_HI:`ACAS_IMM_LO];
        is_word = (req_i.instr[`ACAS_OPC_HI:`ACAS_OPC_LO] == `ACAS_OPC_MEM)
                && (opf == `ACAS_OPF_WORD);
        is_dbl  = (req_i.instr[`ACAS_OPC_HI:`ACAS_OPC_LO] == `ACAS_OPC_MEM)
                && (opf == `ACAS_OPF_DBL);
        // space from register or from immediate field
        sel_spc = isel ? req_i.spc_reg : imm_spc;
    end

    // compare: full width or low word only
    always_comb
    begin
        if (q.dbl)
            mem_hit = (mem_rdata_i == q.cmp);
        else
            mem_hit = (mem_rdata_i[31:0] == q.cmp[31:0]);
    end

    // handshake outputs
    assign req_ready_o  = (q.phase == st_idle) && q.enable;
    assign accept       = req_valid_i && req_ready_o;
    assign resp_valid_o = (q.phase == st_done);
    assign rd_we_o      = resp_valid_o && (q.fault == flt_none);
    assign rd_data_o    = q.rd;
    assign fault_o      = q.fault;
    // condition codes are never written by this unit
    assign ccr_we_o     = 1'b0;
    // interrupts held off from acceptance to answer
    assign intr_hold_o  = (q.phase != st_idle);

    // memory port: both accesses locked as one unit
    assign mem_req_o    = (q.phase == st_read) || (q.phase == st_write);
    assign mem_o.we     = (q.phase == st_write);
    assign mem_o.dbl    = q.dbl;
    assign mem_o.lock   = mem_req_o;
    assign mem_o.spc    = q.spc;
    assign mem_o.addr   = q.addr;
    assign mem_o.wdata  = q.wdata;

    // wishbone outputs
    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.dat;
    assign wb_req   = wb_cyc_i && wb_stb_i && !q.ack;
    assign wb_off   = wb_adr_i[7:0];

    // interrupt level
    assign irq_o = |(q.istat & q.imask);

    // next-state logic for sequencer and registers
    always_comb
    begin
        logic [2:0] iset;         // events this cycle
        logic [2:0] iclr;         // software clears
        logic       misal;        // alignment violation
        iset  = '0;
        iclr  = '0;
        misal = 1'b0;
        d     = q;
        d.ack = 1'b0;

        unique case (q.phase)
            st_idle:
            begin
                if (accept)
                begin
                    d.dbl   = is_dbl;
                    d.spc   = sel_spc;
                    d.addr  = req_i.addr_src;
                    d.cmp   = req_i.cmp_src;
                    d.swap  = req_i.swap_src;
                    d.match = 1'b0;
                    misal   = is_dbl
                        ? ((req_i.addr_src[2:0] & `ACAS_ALN_DBL) != 3'h0)
                        : ((req_i.addr_src[2:0] & `ACAS_ALN_WORD) != 3'h0);
                    // faults are checked before any memory access
                    if (!(is_word || is_dbl))
                        d.fault = flt_bad_encoding;
                    else if (isel && (imm_spc != 8'h00))
                        d.fault = flt_bad_encoding;
                    else if (misal)
                        d.fault = flt_misalign;
                    else if (spc_priv_bad(sel_spc, req_i.priv, req_i.hpriv))
                        d.fault = flt_priv_action;
                    else if (!spc_ok(sel_spc))
                        d.fault = flt_bad_space;
                    else
                        d.fault = flt_none;
                    d.phase = (d.fault == flt_none) ? st_read : st_done;
                end
            end
            st_read:
            begin
                if (mem_ack_i)
                begin
                    if (mem_err_i)
                    begin
                        d.fault = flt_load_err;
                        d.phase = st_done;
                    end
                    else
                    begin
                        d.match = mem_hit;
                        // old value kept on hit and miss; written to the register only if the store does not fault
                        if (q.dbl)
                            d.rd = mem_rdata_i;
                        else
                            d.rd = {32'h0, mem_rdata_i[31:0]};
                        // store always happens; miss rewrites old data
                        if (mem_hit)
                            d.wdata = q.dbl ? q.swap
                                    : {32'h0, q.swap[31:0]};
                        else
                            d.wdata = mem_rdata_i;
                        d.phase = st_write;
                    end
                end
            end
            st_write:
            begin
                if (mem_ack_i)
                begin
                    // store-side error after a clean load
                    if (mem_err_i)
                        d.fault = flt_store_err;
                    d.phase = st_done;
                end
            end
            st_done:
            begin
                d.phase = st_idle;
                d.count = q.count + 16'h1;
                if (q.fault != flt_none)
                    iset[`ACAS_IRQ_FAULT] = 1'b1;
                else if (q.match)
                    iset[`ACAS_IRQ_MATCH] = 1'b1;
                else
                    iset[`ACAS_IRQ_MISS] = 1'b1;
            end
        endcase

        // register access, answered one cycle after the strobe
        if (wb_req)
        begin
            d.ack = 1'b1;
            d.dat = 32'h0;
            unique case (wb_off)
                `ACAS_REG_CTRL:
                begin
                    d.dat = {31'h0, q.enable};
                    if (wb_we_i && wb_sel_i[0])
                        d.enable = wb_dat_i[0];
                end
                `ACAS_REG_STATUS:
                    d.dat = {24'h0, q.fault, 3'h0, q.phase != st_idle,
                             q.match};
                `ACAS_REG_ISTAT:
                begin
                    d.dat = {29'h0, q.istat};
                    if (wb_we_i && wb_sel_i[0])
                        iclr = wb_dat_i[2:0];
                end
                `ACAS_REG_IMASK:
                begin
                    d.dat = {29'h0, q.imask};
                    if (wb_we_i && wb_sel_i[0])
                        d.imask = wb_dat_i[2:0];
                end
                `ACAS_REG_COUNT:
                    d.dat = {16'h0, q.count};
                default:
                    d.dat = 32'h0;   // unmapped reads zero, still acked
            endcase
        end

        // a new event wins over a simultaneous clear
        d.istat = (q.istat & ~iclr) | iset;
    end

    // state register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q        <= '0;
            q.phase  <= st_idle;
            q.fault  <= flt_none;
            q.enable <= `ACAS_CTRL_RST;
            q.imask  <= `ACAS_MASK_RST;
        end
        else
            q <= d;
    end

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    word_upper_zero_a: assert property (
        rd_we_o && !q.dbl |-> rd_data_o[63:32] == 32'h0)
        else $error("word result has nonzero upper half");

    enc_fault_a: assert property (
        accept && isel && imm_spc != 8'h00
        |=> resp_valid_o && fault_o == flt_bad_encoding && !mem_req_o)
        else $error("bad encoding not reported at once");

    misal_no_mem_a: assert property (
        accept && (is_word || is_dbl) && !isel
            && req_i.addr_src[1:0] != 2'h0
        |=> !mem_req_o && resp_valid_o)
        else $error("misaligned request reached memory");

    user_priv_a: assert property (
        accept && (is_word || is_dbl) && !isel && !req_i.priv
            && !req_i.hpriv && !imm_spc[7]
            && req_i.addr_src[2:0] == 3'h0
        |=> fault_o == flt_priv_action)
        else $error("user access to privileged space not faulted");

    store_follows_a: assert property (
        q.phase == st_read && mem_ack_i && !mem_err_i
        |=> mem_req_o && mem_o.we)
        else $error("store did not follow the load");

    miss_keeps_a: assert property (
        q.phase == st_read && mem_ack_i && !mem_err_i && !mem_hit
        |=> mem_o.wdata == $past(mem_rdata_i))
        else $error("miscompare changed memory data");

    hit_swaps_a: assert property (
        q.phase == st_read && mem_ack_i && !mem_err_i && mem_hit && q.dbl
        |=> mem_o.wdata == q.swap)
        else $error("match did not store swap value");

    locked_hold_a: assert property (
        mem_req_o |-> mem_o.lock && intr_hold_o && !req_ready_o)
        else $error("atomic access not locked");

    irq_raise_a: assert property (
        resp_valid_o && q.fault != flt_none && q.imask[`ACAS_IRQ_FAULT]
        |=> irq_o)
        else $error("fault interrupt not raised");

    no_ccr_a: assert property (
        resp_valid_o |-> !ccr_we_o)
        else $error("condition codes written");

    word_hit_a: assert property (
        q.phase == st_read && mem_ack_i && !mem_err_i && mem_hit && !q.dbl
        |=> mem_o.wdata == {32'h0, q.swap[31:0]})
        else $error("word match did not store swap value");

    store_err_a: assert property (
        q.phase == st_write && mem_ack_i && mem_err_i
        |=> resp_valid_o && fault_o == flt_store_err)
        else $error("store error not reported");

    load_stop_a: assert property (
        q.phase == st_read && mem_ack_i && mem_err_i
        |=> resp_valid_o && !mem_req_o && !rd_we_o)
        else $error("failed load went on to store");

    resp_pulse_a: assert property (
        resp_valid_o |=> !resp_valid_o)
        else $error("answer held over two cycles");

    ack_pulse_a: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("bus ack held over two cycles");

    priv_range_a: assert property (
        accept && (is_word || is_dbl) && !isel && req_i.priv
            && !req_i.hpriv && req_i.addr_src[2:0] == 3'h0
            && imm_spc >= `ACAS_SPC_RSV_LO
            && imm_spc <= `ACAS_SPC_RSV_HI
        |=> fault_o == flt_priv_action)
        else $error("reserved space not faulted");

    space_sel_a: assert property (
        accept && isel
        |=> mem_o.spc == $past(req_i.spc_reg))
        else $error("space register not used");

    space_imm_a: assert property (
        accept && !isel
        |=> mem_o.spc == $past(imm_spc))
        else $error("immediate space field not used");

endmodule

// >>> verilog/acas_params.svh
// constants for the atomic compare-and-swap unit
//
// Overview of operation
// - doubleword form compares all 64 bits
// - doubleword match swaps register and memory
// - doubleword miss loads memory, memory kept
// - word form compares low 32 bits only
// - word match swaps low half, upper cleared
// - word miss loads word, upper half zeroed
// - read, compare, store indivisible; no interrupts
// - always stores; write permission always needed
// - space from immediate or space register
// - select set, bits 12:5 nonzero: bad encoding
// - misaligned address faults, no memory access
// - user mode: space bit 7 clear faults
// - privileged mode: spaces 30 to 7f fault
// - condition codes never changed
// - only sixteen spaces allowed, else bad_space_fault
// - store access error may follow clean load
// - operation_field 3c word, 3e doubleword
`ifndef ACAS_PARAMS_SVH
`define ACAS_PARAMS_SVH

// instruction fields
`define ACAS_OPF_HI      24
`define ACAS_OPF_LO      19
`define ACAS_ISEL_BIT    13
`define ACAS_IMM_HI      12
`define ACAS_IMM_LO      5
`define ACAS_OPC_HI      31
`define ACAS_OPC_LO      30
`define ACAS_OPC_MEM     2'h3
`define ACAS_OPF_WORD    6'h3c
`define ACAS_OPF_DBL     6'h3e

// address space codes
`define ACAS_SPC_PRIV_BIT 7
`define ACAS_SPC_RSV_LO   8'h30
`define ACAS_SPC_RSV_HI   8'h7f
`define ACAS_SPC_NUC      8'h04
`define ACAS_SPC_NUC_L    8'h0c
`define ACAS_SPC_USR_P    8'h10
`define ACAS_SPC_USR_S    8'h11
`define ACAS_SPC_USR_P_L  8'h18
`define ACAS_SPC_USR_S_L  8'h19
`define ACAS_SPC_REAL     8'h14
`define ACAS_SPC_REAL_L   8'h1c
`define ACAS_SPC_PRV_P    8'h24
`define ACAS_SPC_PRV_S    8'h25
`define ACAS_SPC_PRV_P_L  8'h2c
`define ACAS_SPC_PRV_S_L  8'h2d
`define ACAS_SPC_PRI      8'h80
`define ACAS_SPC_SEC      8'h81
`define ACAS_SPC_PRI_L    8'h88
`define ACAS_SPC_SEC_L    8'h89

// alignment masks
`define ACAS_ALN_WORD    3'h3
`define ACAS_ALN_DBL     3'h7

// register map (byte addresses)
`define ACAS_REG_CTRL    8'h00
`define ACAS_REG_STATUS  8'h04
`define ACAS_REG_ISTAT   8'h08
`define ACAS_REG_IMASK   8'h0c
`define ACAS_REG_COUNT   8'h10

// interrupt bit positions and reset values
`define ACAS_IRQ_MATCH   0
`define ACAS_IRQ_MISS    1
`define ACAS_IRQ_FAULT   2
`define ACAS_IRQ_W       3
`define ACAS_CTRL_RST    1'h1
`define ACAS_MASK_RST    3'h0
`define ACAS_CNT_W       16

`endif

// >>> verilog/acas_pkg.sv
// types for the atomic compare-and-swap unit
package acas_pkg;

    // sequencing phases
    typedef enum logic [1:0] {st_idle, st_read, st_write, st_done}
        acas_phase_t;

    // fault reported with the answer
    typedef enum logic [2:0]
    {
        flt_none,
        flt_bad_encoding,
        flt_misalign,
        flt_priv_action,
        flt_bad_space,
        flt_load_err,
        flt_store_err
    } acas_fault_t;

    // request from the pipeline
    typedef struct packed
    {
        logic [31:0] instr;       // raw instruction word
        logic [63:0] addr_src;    // address_source_reg value
        logic [63:0] cmp_src;     // compare_source_reg value
        logic [63:0] swap_src;    // swap destination value
        logic [7:0]  spc_reg;     // space identifier register
        logic        priv;        // privileged mode bit
        logic        hpriv;       // hyperprivileged mode bit
    } acas_req_t;

    // request to the memory system
    typedef struct packed
    {
        logic        we;          // store access
        logic        dbl;         // doubleword size
        logic        lock;        // hold off other updates
        logic [7:0]  spc;         // selected space
        logic [63:0] addr;        // byte address
        logic [63:0] wdata;       // store data
    } acas_mem_t;

    // whole module state
    typedef struct packed
    {
        acas_phase_t phase;
        logic        dbl;
        logic        match;
        acas_fault_t fault;
        logic [7:0]  spc;
        logic [63:0] addr;
        logic [63:0] cmp;
        logic [63:0] swap;
        logic [63:0] wdata;
        logic [63:0] rd;
        logic        enable;
        logic [2:0]  istat;
        logic [2:0]  imask;
        logic [15:0] count;
        logic        ack;
        logic [31:0] dat;
    } acas_state_t;

endpackage

// >>> bench/acas_mem_model.sv
// memory-side model answering the compare-and-swap unit
`timescale 1ns/1ps

module acas_mem_model
    import acas_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // request from the unit
    input  wire logic        req_i,
    input  wire acas_mem_t   mem_i,
    // behaviour knobs from the bench
    input  wire logic [3:0]  lat_i,
    input  wire logic        err_rd_i,
    input  wire logic        err_wr_i,
    // answer to the unit
    output logic             ack_o,
    output logic             err_o,
    output logic [63:0]      rdata_o
);
    logic [31:0] mem [0:15];   // big-endian words, bench preloads
    logic [63:0] rd_q = '0;    // last read value
    logic        err_q = 1'b0; // error of last access
    logic [3:0]  cnt;          // wait cycles so far
    int          nacc = 0;     // accesses answered
    int          nwr = 0;      // stores answered
    logic [3:0]  wi;           // word index of access

    assign wi = mem_i.addr[5:2];
    // data only means something with ack; else flip it so no stale match
    assign rdata_o = ack_o ? rd_q : ~rd_q;
    assign err_o   = ack_o & err_q;

    // one access at a time; the lock bit of the request is not looked at
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            cnt   <= 4'h0;
        end
        else if (ack_o)
        begin
            ack_o <= 1'b0;         // pulse only
            cnt   <= 4'h0;
        end
        else if (req_i && cnt < lat_i)
            cnt <= cnt + 4'h1;     // slow answer
        else if (req_i)
        begin
            ack_o <= 1'b1;
            nacc  <= nacc + 1;
            err_q <= mem_i.we ? err_wr_i : err_rd_i;
            if (!mem_i.we && mem_i.dbl)
                rd_q <= {mem[wi & 4'he], mem[wi | 4'h1]};
            else if (!mem_i.we)
                rd_q <= {~mem[wi], mem[wi]};   // upper half is junk
            else
            begin
                nwr <= nwr + 1;
                // a failed store leaves memory alone
                if (!err_wr_i && mem_i.dbl)
                    {mem[wi & 4'he], mem[wi | 4'h1]} <= mem_i.wdata;
                else if (!err_wr_i)
                    mem[wi] <= mem_i.wdata[31:0];
            end
        end
    end
endmodule

// >>> bench/acas_unit_tb_top.sv
// self-checking bench for the compare-and-swap unit
`timescale 1ns/1ps

module acas_unit_tb_top import acas_pkg::*;;
    // one case: request fields beside the expected answer
    typedef struct {
        logic [5:0]  opf;
        logic        isel;
        logic [7:0]  imm;
        logic [63:0] adr, cmp, swp;
        logic [7:0]  sr;
        logic [1:0]  md;     // hyperprivileged, privileged
        acas_fault_t f;
        logic [63:0] rd, mem;
    } acas_row_t;

    localparam logic [63:0] pat = 64'h1122334455667788;
    localparam logic [63:0] swv = 64'h99aabbccddeeff00;
    localparam logic [5:0]  wrd = 6'h3c;
    localparam logic [5:0]  dbl = 6'h3e;
    localparam logic [7:0]  sp [16] = '{8'h04, 8'h0c, 8'h10, 8'h18,
        8'h11, 8'h19, 8'h14, 8'h1c, 8'h24, 8'h2c, 8'h25, 8'h2d,
        8'h80, 8'h88, 8'h81, 8'h89};

    logic        clk_i, rst_i, req_valid_i, req_ready_o, resp_valid_o;
    logic        rd_we_o, ccr_we_o, intr_hold_o, mem_req_o, irq_o;
    logic        mem_ack_i, mem_err_i, err_rd, err_wr;
    logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [3:0]  wb_sel_i, lat;
    logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, q;
    logic [63:0] rd_data_o, mem_rdata_i;
    acas_req_t   req_i;
    acas_fault_t fault_o;
    acas_mem_t   mem_o;
    acas_row_t   rows[$];
    int          n_fail = 0;
    int          n_tests = 0;

    acas_unit i_dut (.clk_i, .rst_i, .req_valid_i, .req_ready_o, .req_i,
        .resp_valid_o, .rd_we_o, .rd_data_o, .fault_o, .ccr_we_o,
        .intr_hold_o, .mem_req_o, .mem_o, .mem_ack_i, .mem_err_i,
        .mem_rdata_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o);

    acas_mem_model i_mem (.clk_i, .rst_i, .req_i(mem_req_o), .mem_i(mem_o),
        .lat_i(lat), .err_rd_i(err_rd), .err_wr_i(err_wr),
        .ack_o(mem_ack_i), .err_o(mem_err_i), .rdata_o(mem_rdata_i));

    // 40 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // final verdict, the only exit
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // compare one value, four-state exact
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // a wait that ran out counts as a mismatch and ends the run
    task automatic hang();
        chk(64'h0, 64'h1);
        tally_and_finish();
    endtask

    // classic wishbone single cycle, entered just after an edge
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        int k;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {24'h0, a};
        wb_dat_i <= d;
        for (k = 0; k < 20; k++)
        begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1)
                break;
        end
        if (k == 20)
            hang();
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic add(input logic [5:0] o, input logic i,
        input logic [7:0] m, input logic [63:0] a, c, s,
        input logic [7:0] r, input logic [1:0] md, input acas_fault_t f,
        input logic [63:0] rd, mm);
        rows.push_back('{o, i, m, a, c, s, r, md, f, rd, mm});
    endtask

    // one instruction: preload, issue, wait, compare
    task automatic run(input acas_row_t r);
        int k, a0, w0, ea;
        logic [3:0] b;
        b = r.adr[5:2] & 4'he;
        i_mem.mem[b] = pat[63:32];
        i_mem.mem[b | 4'h1] = pat[31:0];
        a0 = i_mem.nacc;
        w0 = i_mem.nwr;
        ea = r.f == flt_load_err ? 1 : 0;
        ea = (r.f == flt_none || r.f == flt_store_err) ? 2 : ea;
        req_valid_i <= 1'b1;
        req_i <= '{instr: {2'h3, 5'h0, r.opf, 5'h0, r.isel, r.imm, 5'h0},
                   addr_src: r.adr, cmp_src: r.cmp, swap_src: r.swp,
                   spc_reg: r.sr, priv: r.md[0], hpriv: r.md[1]};
        // taken at the first edge that sees ready high
        for (k = 0; k < 50; k++)
        begin
            @(posedge clk_i);
            if (req_ready_o === 1'b1)
                break;
        end
        if (k == 50)
            hang();
        req_valid_i <= 1'b0;
        for (k = 0; k < 60; k++)
        begin
            @(posedge clk_i);
            if (mem_req_o === 1'b1)
                chk({intr_hold_o, mem_o.lock}, 2'h3);
            if (resp_valid_o === 1'b1)
                break;
        end
        if (k == 60)
            hang();
        chk(fault_o, r.f);
        chk(rd_we_o, r.f == flt_none);
        if (r.f == flt_none)
            chk(rd_data_o, r.rd);
        chk(ccr_we_o, 1'b0);
        chk({i_mem.mem[b], i_mem.mem[b | 4'h1]}, r.mem);
        chk(i_mem.nacc - a0, ea);
        chk(i_mem.nwr - w0, ea / 2);
    endtask

    initial
    begin
        rst_i = 1'b1;
        req_valid_i = 1'b0;
        req_i = '0;
        {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
        wb_adr_i = 32'h0;
        wb_dat_i = 32'h0;
        wb_sel_i = 4'hf;
        {lat, err_rd, err_wr} = 6'h0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        chk({req_ready_o, resp_valid_o, mem_req_o, irq_o}, 4'h8);
        @(posedge clk_i);
        wb(1'b0, 8'h00, 32'h0, q);
        chk(q, 32'h1);
        wb(1'b0, 8'h0c, 32'h0, q);
        chk(q, 32'h0);
        wb(1'b1, 8'h40, 32'hff, q);
        wb(1'b0, 8'h40, 32'h0, q);
        chk(q, 32'h0);
        $display("test reset and registers done");
        add(dbl, 0, 8'h80, 8'h08, pat, swv, 8'h30, 1, flt_none, pat, swv);
        add(dbl, 0, 8'h80, 8'h08, pat ^ 64'h8000000000000000, swv, 8'h30, 1, flt_none, pat, pat);
        add(wrd, 0, 8'h80, 8'h10, 64'hffffffff11223344, swv, 8'h30, 1, flt_none, 64'h11223344, 64'hddeeff0055667788);
        add(wrd, 0, 8'h80, 8'h14, 64'h0, swv, 8'h30, 1, flt_none, 64'h55667788, pat);
        add(dbl, 1, 8'h00, 8'h08, pat, swv, 8'h88, 1, flt_none, pat, swv);
        add(dbl, 1, 8'h01, 8'h08, pat, swv, 8'h88, 1, flt_bad_encoding, 0, pat);
        add(dbl, 0, 8'h80, 8'h0c, pat, swv, 8'h30, 1, flt_misalign, 0, pat);
        add(wrd, 0, 8'h80, 8'h12, pat, swv, 8'h30, 1, flt_misalign, 0, pat);
        add(dbl, 0, 8'h80, 8'h08, pat, swv, 8'h30, 0, flt_none, pat, swv);
        add(dbl, 0, 8'h04, 8'h08, pat, swv, 8'h30, 0, flt_priv_action, 0, pat);
        add(dbl, 0, 8'h30, 8'h08, pat, swv, 8'h30, 1, flt_priv_action, 0, pat);
        add(dbl, 0, 8'h7f, 8'h08, pat, swv, 8'h30, 1, flt_priv_action, 0, pat);
        add(dbl, 0, 8'h30, 8'h08, pat, swv, 8'h30, 2, flt_bad_space, 0, pat);
        add(dbl, 0, 8'h82, 8'h08, pat, swv, 8'h30, 1, flt_bad_space, 0, pat);
        add(6'h3d, 0, 8'h80, 8'h08, pat, swv, 8'h30, 1, flt_bad_encoding, 0, pat);
        foreach (sp[k])
            add(dbl, 0, sp[k], 8'h08, pat, swv, 8'h30, 1, flt_none, pat, swv);
        foreach (rows[k])
            run(rows[k]);
        $display("test table done");
        // slow memory, then a failed load and a failed store
        lat <= 4'h3;
        run(rows[0]);
        lat <= 4'h0;
        err_rd <= 1'b1;
        add(dbl, 0, 8'h80, 8'h08, pat, swv, 8'h30, 1, flt_load_err, 0, pat);
        run(rows.pop_back());
        err_rd <= 1'b0;
        err_wr <= 1'b1;
        add(dbl, 0, 8'h80, 8'h08, pat, swv, 8'h30, 1, flt_store_err, 0, pat);
        run(rows.pop_back());
        err_wr <= 1'b0;
        wb(1'b0, 8'h04, 32'h0, q);
        chk(q, 32'hc1);
        wb(1'b0, 8'h10, 32'h0, q);
        chk(q, 32'h22);
        $display("test memory errors done");
        // sticky status, mask, write-one-to-clear
        wb(1'b0, 8'h08, 32'h0, q);
        chk(q, 32'h7);
        wb(1'b1, 8'h0c, 32'h2, q);
        chk(irq_o, 1'b1);
        wb(1'b1, 8'h08, 32'h2, q);
        chk(irq_o, 1'b0);
        wb(1'b0, 8'h08, 32'h0, q);
        chk(q, 32'h5);
        wb(1'b1, 8'h00, 32'h0, q);
        chk(req_ready_o, 1'b0);
        wb(1'b1, 8'h00, 32'h1, q);
        chk(req_ready_o, 1'b1);
        $display("test interrupt and enable done");
        tally_and_finish();
    end
endmodule
